// ### design/sdwb_pkg.sv
package sdwb_pkg;
   // ------------------------------------------------------------
   // Register map and field layout
   // ------------------------------------------------------------
   localparam logic [7:0] BUF_CTRL_OFFSET = 8'h40;
   localparam logic [7:0] BUF_CTRL_RESET = 8'h00;
   localparam int WB_ENABLE_BIT = 0;
   localparam int FLUSH_REQ_BIT = 1;
   localparam int WMARK_LSB = 2;
   localparam int READAHEAD_BIT = 4;
   localparam logic [7:0] BUF_CTRL_WMASK = 8'h1D;
   // ------------------------------------------------------------
   // Buffer geometry and watermark levels in doublewords
   // ------------------------------------------------------------
   localparam int RANKS = 32;
   localparam int RANK_AW = 5;
   localparam int LINE_DW = 4;
   localparam logic [5:0] WMARK_28 = 6'h1C;
   localparam logic [5:0] WMARK_24 = 6'h18;
   localparam logic [5:0] WMARK_16 = 6'h10;
   localparam logic [5:0] WMARK_8 = 6'h08;
   localparam logic [1:0] MASTER_CPU = 2'h0;
   localparam logic [1:0] MASTER_PCI = 2'h1;
   localparam logic [1:0] MASTER_DMA = 2'h2;
   localparam logic [2:0] CMD_WRITE = 3'h1;
   localparam logic [2:0] CMD_LINE = 3'h2;
   localparam logic [2:0] CMD_LINE_AHEAD = 3'h3;
   typedef enum logic [2:0] {
      SDWB_IDLE  = 3'b001,
      SDWB_DRAIN = 3'b010,
      SDWB_FLUSH = 3'b100
   } sdwb_state_t;
endpackage

// ### design/sdwb_rank_store.sv
module sdwb_rank_store
   import sdwb_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic clear,
   input wire logic wr_en,
   input wire logic [25:0] wr_addr,
   input wire logic [31:0] wr_data,
   input wire logic [3:0] wr_be,
   input wire logic pop,
   input wire logic [25:0] look_addr,
   output logic look_hit,
   output logic [31:0] look_data,
   output logic [3:0] look_be,
   output logic [5:0] count,
   output logic [25:0] head_addr,
   output logic [31:0] head_data,
   output logic [3:0] head_be,
   output logic write_merged
);
   logic [25:0] addr_ff [RANKS];
   logic [31:0] data_ff [RANKS];
   logic [3:0] be_ff [RANKS];
   logic [RANKS-1:0] vld_ff;
   logic [RANK_AW-1:0] rd_ff, wr_ff;
   logic [5:0] cnt_ff;
   logic [31:0] nxt_data [RANKS];
   logic [3:0] nxt_be [RANKS];
   logic [25:0] nxt_addr [RANKS];
   logic [RANKS-1:0] nxt_vld;
   logic [RANK_AW-1:0] nxt_rd, nxt_wr;
   logic [5:0] nxt_cnt;
   logic whit, lhit;
   logic [RANK_AW-1:0] widx, lidx;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = din[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Newest matching rank wins; merging is only legal into the tail (newest) rank for that address.
   always_comb begin
      whit = 1'b0;
      widx = '0;
      lhit = 1'b0;
      lidx = '0;
      for (int i = 0; i < RANKS; i++) begin
         if (vld_ff[i] && addr_ff[i] == wr_addr && !(pop && RANK_AW'(i) == rd_ff)) begin
            whit = 1'b1;
            widx = RANK_AW'(i);
         end
         if (vld_ff[i] && addr_ff[i] == look_addr) begin
            lhit = 1'b1;
            lidx = RANK_AW'(i);
         end
      end
   end

   always_comb begin
      nxt_data = data_ff;
      nxt_be = be_ff;
      nxt_addr = addr_ff;
      nxt_vld = vld_ff;
      nxt_rd = rd_ff;
      nxt_wr = wr_ff;
      nxt_cnt = cnt_ff;
      if (clear) begin
         nxt_vld = '0;
         nxt_rd = '0;
         nxt_wr = '0;
         nxt_cnt = '0;
      end else begin
         if (pop && cnt_ff != 6'h00) begin
            nxt_vld[rd_ff] = 1'b0;
            nxt_rd = rd_ff + 1'b1;
            nxt_cnt = nxt_cnt - 6'h01;
         end
         if (wr_en && whit) begin
            nxt_data[widx] = merge(data_ff[widx], wr_data, wr_be);
            nxt_be[widx] = be_ff[widx] | wr_be;
         end else if (wr_en) begin
            nxt_addr[wr_ff] = wr_addr;
            nxt_data[wr_ff] = wr_data;
            nxt_be[wr_ff] = wr_be;
            nxt_vld[wr_ff] = 1'b1;
            nxt_wr = wr_ff + 1'b1;
            nxt_cnt = nxt_cnt + 6'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         vld_ff <= '0;
         rd_ff <= '0;
         wr_ff <= '0;
         cnt_ff <= '0;
      end else if (ce) begin
         vld_ff <= nxt_vld;
         rd_ff <= nxt_rd;
         wr_ff <= nxt_wr;
         cnt_ff <= nxt_cnt;
      end
   end

   always_ff @(posedge clk) begin
      if (ce) begin
         addr_ff <= nxt_addr;
         data_ff <= nxt_data;
         be_ff <= nxt_be;
      end
   end

   assign look_hit = lhit;
   assign look_data = data_ff[lidx];
   assign look_be = be_ff[lidx];
   assign count = cnt_ff;
   assign head_addr = addr_ff[rd_ff];
   assign head_data = data_ff[rd_ff];
   assign head_be = be_ff[rd_ff];
   assign write_merged = wr_en && whit;
endmodule // sdwb_rank_store

// ### design/sdwb_buffer.sv
// Summary of operation
// - With read-ahead on, a burst read fetches the current line and also prefetches the next line.
// - A single read fetches only the rest of the current line, with no prefetch.
// - Read-ahead applies to CPU and PCI burst reads; DMA reads never trigger it.
// - Watermark field 00/01/10/11 selects 28/24/16/8 doublewords.
// - Each write takes a new rank unless it merges into an allocated rank.
// - A write taking the rank count above the watermark starts draining to SDRAM.
// - Writing 1 to the flush bit starts a flush that reads 1 until done; writing 0 does nothing.
// - A flush drains all ranks before any other SDRAM read or write is allowed.
// - With the buffer enabled all CPU, PCI and DMA writes are buffered; else it is off.
// - An enabled buffer merges writes and returns buffered data to reads that hit it.
// - Write buffer and read-ahead have separate enable bits.
// - The control register at 40h resets to zero; bits 7-5 are reserved and read 0.
module sdwb_buffer
   import sdwb_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] cfg_rdata,
   input wire logic m_req,
   input wire logic m_write,
   input wire logic m_burst,
   input wire logic [1:0] m_src,
   input wire logic [25:0] m_addr,
   input wire logic [31:0] m_wdata,
   input wire logic [3:0] m_be,
   output logic m_ack,
   output logic m_hit,
   output logic [31:0] m_rdata,
   output logic [3:0] m_hit_be,
   output logic sd_req,
   output logic [2:0] sd_cmd,
   output logic [25:0] sd_addr,
   output logic [31:0] sd_wdata,
   output logic [3:0] sd_be,
   output logic sd_hipri,
   input wire logic sd_ack
);
   sdwb_state_t st_ff, nxt_st;
   logic wb_en_ff, nxt_wb_en;
   logic ra_en_ff, nxt_ra_en;
   logic [1:0] wm_ff, nxt_wm;
   logic flush_ff, nxt_flush;
   logic [7:0] rdata_ff, nxt_rdata;
   logic ack_ff, nxt_ack;
   logic hit_ff, nxt_hit;
   logic [31:0] mrd_ff, nxt_mrd;
   logic [3:0] hbe_ff, nxt_hbe;
   logic req_ff, nxt_req;
   logic [2:0] cmd_ff, nxt_cmd;
   logic [25:0] sadr_ff, nxt_sadr;
   logic [31:0] swd_ff, nxt_swd;
   logic [3:0] sbe_ff, nxt_sbe;
   logic hipri_ff, nxt_hipri;
   logic pop, buf_wr, lhit;
   logic [5:0] cnt, post_cnt;
   logic [25:0] head_addr;
   logic [31:0] head_data, ldata;
   logic [3:0] head_be, lbe;

   function automatic logic [5:0] wmark_level(input logic [1:0] sel);
      unique case (sel)
         2'b00: return WMARK_28;
         2'b01: return WMARK_24;
         2'b10: return WMARK_16;
         2'b11: return WMARK_8;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Rank storage
   // ------------------------------------------------------------
   sdwb_rank_store u_ranks (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .clear(1'b0),
      .wr_en(buf_wr),
      .wr_addr(m_addr),
      .wr_data(m_wdata),
      .wr_be(m_be),
      .pop(pop),
      .look_addr(m_addr),
      .look_hit(lhit),
      .look_data(ldata),
      .look_be(lbe),
      .count(cnt),
      .head_addr(head_addr),
      .head_data(head_data),
      .head_be(head_be),
      .write_merged()
   );

   // ------------------------------------------------------------
   // Control register and sequencing
   // ------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_wb_en = wb_en_ff;
      nxt_ra_en = ra_en_ff;
      nxt_wm = wm_ff;
      nxt_flush = flush_ff;
      nxt_rdata = rdata_ff;
      nxt_ack = 1'b0;
      nxt_hit = 1'b0;
      nxt_mrd = mrd_ff;
      nxt_hbe = hbe_ff;
      nxt_req = req_ff;
      nxt_cmd = cmd_ff;
      nxt_sadr = sadr_ff;
      nxt_swd = swd_ff;
      nxt_sbe = sbe_ff;
      nxt_hipri = 1'b0;
      pop = 1'b0;
      buf_wr = 1'b0;
      post_cnt = cnt;
      if (cfg_wr && cfg_addr == BUF_CTRL_OFFSET) begin
         nxt_wb_en = cfg_wdata[WB_ENABLE_BIT];
         nxt_ra_en = cfg_wdata[READAHEAD_BIT];
         nxt_wm = cfg_wdata[WMARK_LSB +: 2];
      end
      if (cfg_rd) begin
         nxt_rdata = (cfg_addr == BUF_CTRL_OFFSET) ?
            {3'b000, ra_en_ff, wm_ff, flush_ff, wb_en_ff} : 8'h00;
      end
      // An outstanding SDRAM request blocks all new master work until acknowledged.
      if (req_ff) begin
         if (sd_ack) begin
            nxt_req = 1'b0;
            pop = (cmd_ff == CMD_WRITE) && (st_ff != SDWB_IDLE);
         end
      end else unique case (st_ff)
         SDWB_IDLE: begin
            if (flush_ff) begin
               nxt_st = SDWB_FLUSH;
            end else if (ack_ff) begin
               // The master still shows its request in the acknowledge cycle; it is not taken twice.
               nxt_st = SDWB_IDLE;
            end else if (m_req && m_write && wb_en_ff) begin
               buf_wr = 1'b1;
               nxt_ack = 1'b1;
               // Nothing is popped while idle, so a lookup hit is exactly a merge.
               post_cnt = lhit ? cnt : cnt + 6'h01;
               if (post_cnt > wmark_level(wm_ff)) begin
                  nxt_st = SDWB_DRAIN;
               end
            end else if (m_req && m_write) begin
               nxt_req = 1'b1;
               nxt_cmd = CMD_WRITE;
               nxt_sadr = m_addr;
               nxt_swd = m_wdata;
               nxt_sbe = m_be;
               nxt_ack = 1'b1;
            end else if (m_req) begin
               nxt_ack = 1'b1;
               nxt_hit = wb_en_ff && lhit;
               nxt_mrd = ldata;
               nxt_hbe = lbe;
               nxt_req = 1'b1;
               nxt_sadr = m_addr;
               nxt_sbe = 4'hF;
               if (ra_en_ff && m_burst && m_src != MASTER_DMA) begin
                  nxt_cmd = CMD_LINE_AHEAD;
               end else begin
                  nxt_cmd = CMD_LINE;
               end
            end
         end
         SDWB_DRAIN, SDWB_FLUSH: begin
            if (cnt == 6'h00) begin
               nxt_st = SDWB_IDLE;
               nxt_flush = (st_ff == SDWB_FLUSH) ? 1'b0 : flush_ff;
            end else if (st_ff == SDWB_DRAIN && flush_ff) begin
               nxt_st = SDWB_FLUSH;
            end else begin
               nxt_req = 1'b1;
               nxt_cmd = CMD_WRITE;
               nxt_sadr = head_addr;
               nxt_swd = head_data;
               nxt_sbe = head_be;
               nxt_hipri = st_ff == SDWB_FLUSH;
            end
         end
      endcase
      if (req_ff) begin
         nxt_hipri = hipri_ff && !sd_ack;
      end
      // A new flush request wins over the completion of the flush before it.
      if (cfg_wr && cfg_addr == BUF_CTRL_OFFSET && cfg_wdata[FLUSH_REQ_BIT]) begin
         nxt_flush = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_ff <= SDWB_IDLE;
         wb_en_ff <= BUF_CTRL_RESET[WB_ENABLE_BIT];
         ra_en_ff <= BUF_CTRL_RESET[READAHEAD_BIT];
         wm_ff <= BUF_CTRL_RESET[WMARK_LSB +: 2];
         flush_ff <= BUF_CTRL_RESET[FLUSH_REQ_BIT];
         rdata_ff <= 8'h00;
         ack_ff <= 1'b0;
         hit_ff <= 1'b0;
         mrd_ff <= 32'h0000_0000;
         hbe_ff <= 4'h0;
         req_ff <= 1'b0;
         cmd_ff <= 3'h0;
         sadr_ff <= 26'h000_0000;
         swd_ff <= 32'h0000_0000;
         sbe_ff <= 4'h0;
         hipri_ff <= 1'b0;
      end else if (ce) begin
         st_ff <= nxt_st;
         wb_en_ff <= nxt_wb_en;
         ra_en_ff <= nxt_ra_en;
         wm_ff <= nxt_wm;
         flush_ff <= nxt_flush;
         rdata_ff <= nxt_rdata;
         ack_ff <= nxt_ack;
         hit_ff <= nxt_hit;
         mrd_ff <= nxt_mrd;
         hbe_ff <= nxt_hbe;
         req_ff <= nxt_req;
         cmd_ff <= nxt_cmd;
         sadr_ff <= nxt_sadr;
         swd_ff <= nxt_swd;
         sbe_ff <= nxt_sbe;
         hipri_ff <= nxt_hipri;
      end
   end

   assign cfg_rdata = rdata_ff;
   assign m_ack = ack_ff;
   assign m_hit = hit_ff;
   assign m_rdata = mrd_ff;
   assign m_hit_be = hbe_ff;
   assign sd_req = req_ff;
   assign sd_cmd = cmd_ff;
   assign sd_addr = sadr_ff;
   assign sd_wdata = swd_ff;
   assign sd_be = sbe_ff;
   assign sd_hipri = hipri_ff;
endmodule // sdwb_buffer

// ### tb/sdwb_buffer_checker.sv
module sdwb_buffer_checker
   import sdwb_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [7:0] cfg_rdata,
   input wire logic m_write,
   input wire logic m_burst,
   input wire logic [1:0] m_src,
   input wire logic m_ack,
   input wire logic m_hit,
   input wire logic sd_req,
   input wire logic [2:0] sd_cmd,
   input wire logic [25:0] sd_addr,
   input wire logic sd_hipri,
   input wire logic sd_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   reset_quiet_a: assert property ($rose(rstn) |-> !m_ack && !sd_req && !sd_hipri)
      else $error("outputs active after reset");
   rsvd_zero_a: assert property (cfg_rdata[7:5] == 3'h0)
      else $error("reserved bits read nonzero");
   unmapped_zero_a: assert property (cfg_rd && cfg_addr != BUF_CTRL_OFFSET |=> cfg_rdata == 8'h00)
      else $error("unmapped read not zero");
   req_hold_a: assert property (sd_req && !sd_ack |=> sd_req && $stable(sd_cmd) && $stable(sd_addr))
      else $error("sdram request changed before accept");
   hipri_write_a: assert property (sd_hipri |-> sd_req && sd_cmd == CMD_WRITE)
      else $error("high priority without write request");
   ahead_cause_a: assert property (m_ack && sd_req && sd_cmd == CMD_LINE_AHEAD
      |-> $past(m_burst) && $past(m_src) != MASTER_DMA)
      else $error("prefetch without eligible burst");
   single_line_a: assert property (m_ack && sd_req && !$past(m_write) && !$past(m_burst)
      |-> sd_cmd == CMD_LINE)
      else $error("single read did not fetch line rest only");
   hit_ack_a: assert property (m_hit |-> m_ack && !$past(m_write))
      else $error("hit without read acknowledge");
endmodule // sdwb_buffer_checker

bind sdwb_buffer sdwb_buffer_checker u_chk (.clk(clk), .rstn(rstn), .cfg_rd(cfg_rd),
   .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .m_write(m_write), .m_burst(m_burst),
   .m_src(m_src), .m_ack(m_ack), .m_hit(m_hit), .sd_req(sd_req), .sd_cmd(sd_cmd),
   .sd_addr(sd_addr), .sd_hipri(sd_hipri), .sd_ack(sd_ack));

// ### tb/sdwb_sd_model.sv
module sdwb_sd_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [1:0] slow,
   input wire logic sd_req,
   input wire logic [2:0] sd_cmd,
   input wire logic [25:0] sd_addr,
   input wire logic [31:0] sd_wdata,
   input wire logic [3:0] sd_be,
   input wire logic sd_hipri,
   output logic sd_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [65:0] got[$];
   logic [1:0] wait_ff;
   initial sd_ack = 1'b0;
   // Each accepted request is logged; the next one stalls up to slow cycles.
   always @(posedge clk) begin
      if (!rstn) begin
         sd_ack <= 1'b0;
         wait_ff <= 2'h0;
      end else if (sd_ack) begin
         sd_ack <= 1'b0;
         got.push_back({sd_hipri, sd_cmd, sd_be, sd_addr, sd_wdata});
         wait_ff <= 2'($urandom_range(slow));
      end else if (sd_req) begin
         if (wait_ff == 2'h0) begin
            sd_ack <= 1'b1;
         end else begin
            wait_ff <= wait_ff - 2'h1;
         end
      end
   end
endmodule // sdwb_sd_model

// ### tb/sdwb_buffer_tb_top.sv
module sdwb_buffer_tb_top
   import sdwb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [65:0] RDM = {1'b1, 3'h7, 4'h0, 26'h3ff_fffc, 32'h0000_0000};
   logic clk = 1'b0, rstn = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, m_req = 1'b0, m_write = 1'b0;
   logic m_burst = 1'b0, m_ack, m_hit, sd_req, sd_hipri, sd_ack, hit_q;
   logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
   logic [1:0] m_src = 2'h0, slow = 2'h0;
   logic [25:0] m_addr = 26'h000_0000, sd_addr;
   logic [31:0] m_wdata = 32'h0000_0000, m_rdata, sd_wdata, rdata_q;
   logic [3:0] m_be = 4'h0, m_hit_be, sd_be, hbe_q;
   logic [2:0] sd_cmd;
   int failures = 0, check_count = 0, rd_ix = 0;
   always #4 clk = ~clk;
   sdwb_buffer dut (.clk(clk), .rstn(rstn), .ce(1'b1), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .m_req(m_req),
      .m_write(m_write), .m_burst(m_burst), .m_src(m_src), .m_addr(m_addr), .m_wdata(m_wdata),
      .m_be(m_be), .m_ack(m_ack), .m_hit(m_hit), .m_rdata(m_rdata), .m_hit_be(m_hit_be),
      .sd_req(sd_req), .sd_cmd(sd_cmd), .sd_addr(sd_addr), .sd_wdata(sd_wdata), .sd_be(sd_be),
      .sd_hipri(sd_hipri), .sd_ack(sd_ack));
   sdwb_sd_model sd_model (.clk(clk), .rstn(rstn), .slow(slow), .sd_req(sd_req),
      .sd_cmd(sd_cmd), .sd_addr(sd_addr), .sd_wdata(sd_wdata), .sd_be(sd_be),
      .sd_hipri(sd_hipri), .sd_ack(sd_ack));
   // --------
   // Helpers
   // --------
   function automatic logic [65:0] rec(logic h, logic [2:0] c, logic [3:0] b, logic [25:0] a,
                                       logic [31:0] d);
      return {h, c, b, a, d};
   endfunction
   function automatic logic [7:0] ctl(logic ra, logic [1:0] wm, logic fl, logic en);
      return {3'h0, ra, wm, fl, en};
   endfunction
   function automatic int lvl(logic [1:0] wm);
      return (wm == 2'h0) ? 28 : (wm == 2'h1) ? 24 : (wm == 2'h2) ? 16 : 8;
   endfunction
   task automatic final_report();
      if (failures == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [65:0] g, input logic [65:0] e, input string m);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic cfg_w(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge clk);
      cfg_wr <= 1'b0;
   endtask
   task automatic cfg_r(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      cfg_rd <= 1'b1;
      cfg_addr <= a;
      @(posedge clk);
      cfg_rd <= 1'b0;
      @(posedge clk);
      chk(66'(cfg_rdata), 66'(e), "register read");
   endtask
   task automatic mst(input logic w, input logic b, input logic [1:0] s, input logic [25:0] a,
                      input logic [31:0] d, input logic [3:0] be, input logic p);
      int n;
      n = 0;
      @(posedge clk);
      m_req <= 1'b1;
      m_write <= w;
      m_burst <= b;
      m_src <= s;
      m_addr <= a;
      m_wdata <= d;
      m_be <= be;
      do begin
         @(posedge clk);
         n++;
      end while (!(m_ack || (p && sd_req)) && n < 400);
      m_req <= 1'b0;
      hit_q = m_hit;
      rdata_q = m_rdata;
      hbe_q = m_hit_be;
      chk(66'(n < 400), 66'(1), "master handshake");
   endtask
   task automatic nxt(input logic [65:0] r, input logic [65:0] mk);
      repeat (400) begin
         if (sd_model.got.size() > rd_ix) break;
         @(posedge clk);
      end
      chk(sd_model.got[rd_ix] & mk, r & mk, "sdram request");
      rd_ix++;
   endtask
   // --------
   // Tests
   // --------
   initial begin
      logic [25:0] base;
      logic [31:0] dat [0:28];
      logic [31:0] mrg;
      int lv;
      void'($urandom(32'h0000_bafe));
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      cfg_r(BUF_CTRL_OFFSET, BUF_CTRL_RESET);
      cfg_r(8'h44, 8'h00);
      cfg_w(BUF_CTRL_OFFSET, 8'hfd);
      cfg_r(BUF_CTRL_OFFSET, 8'h1d);
      cfg_w(8'h41, 8'h00);
      cfg_r(BUF_CTRL_OFFSET, 8'h1d);
      cfg_w(BUF_CTRL_OFFSET, 8'h1c);
      base = 26'($urandom);
      mrg = $urandom;
      mst(1'b1, 1'b0, MASTER_PCI, base, mrg, 4'hf, 1'b1);
      nxt(rec(1'b0, CMD_WRITE, 4'hf, base, mrg), '1);
      for (int w = 0; w < 4; w++) begin
         lv = lvl(2'(w));
         base = 26'($urandom) & 26'h3ff_ffc0;
         slow <= 2'($urandom);
         cfg_w(BUF_CTRL_OFFSET, ctl(1'b0, 2'(w), 1'b0, 1'b0));
         cfg_w(BUF_CTRL_OFFSET, ctl(1'b0, 2'(w), 1'b0, 1'b1));
         for (int i = 0; i < lv; i++) begin
            dat[i] = $urandom;
            mst(1'b1, 1'b0, 2'(i % 3), base + 26'(i), dat[i], 4'hf, 1'b0);
         end
         mrg = $urandom;
         mst(1'b1, 1'b0, MASTER_DMA, base, mrg, 4'h1, 1'b0);
         dat[0] = {dat[0][31:8], mrg[7:0]};
         mst(1'b0, 1'b0, MASTER_CPU, base, 32'h0000_0000, 4'hf, 1'b0);
         chk(66'({hit_q, hbe_q, rdata_q}), 66'({1'b1, 4'hf, dat[0]}), "read merge");
         nxt(rec(1'b0, CMD_LINE, 4'h0, base, 32'h0000_0000), RDM);
         dat[lv] = $urandom;
         mst(1'b1, 1'b0, MASTER_PCI, base + 26'(lv), dat[lv], 4'hf, 1'b0);
         for (int i = 0; i <= lv; i++) begin
            nxt(rec(1'b0, CMD_WRITE, 4'hf, base + 26'(i), dat[i]), '1);
         end
      end
      slow <= 2'h3;
      for (int i = 0; i < 3; i++) begin
         dat[i] = $urandom;
         mst(1'b1, 1'b0, MASTER_CPU, base + 26'(i), dat[i], 4'hf, 1'b0);
      end
      cfg_w(BUF_CTRL_OFFSET, ctl(1'b0, 2'h3, 1'b1, 1'b1));
      cfg_r(BUF_CTRL_OFFSET, ctl(1'b0, 2'h3, 1'b1, 1'b1));
      // Three drain writes take at least nine cycles, so the flush is still running here.
      cfg_w(BUF_CTRL_OFFSET, ctl(1'b0, 2'h3, 1'b0, 1'b1));
      cfg_r(BUF_CTRL_OFFSET, ctl(1'b0, 2'h3, 1'b1, 1'b1));
      mst(1'b0, 1'b1, MASTER_CPU, base + 26'(8), 32'h0000_0000, 4'hf, 1'b0);
      for (int i = 0; i < 3; i++) begin
         nxt(rec(1'b1, CMD_WRITE, 4'hf, base + 26'(i), dat[i]), '1);
      end
      nxt(rec(1'b0, CMD_LINE, 4'h0, base + 26'(8), 32'h0000_0000), RDM);
      cfg_r(BUF_CTRL_OFFSET, ctl(1'b0, 2'h3, 1'b0, 1'b1));
      for (int k = 0; k < 12; k++) begin
         logic ra;
         logic b;
         logic [1:0] s;
         ra = k[0];
         b = k[1];
         s = 2'(k / 4);
         cfg_w(BUF_CTRL_OFFSET, ctl(ra, 2'h3, 1'b0, 1'b0));
         base = 26'($urandom);
         mst(1'b0, b, s, base, 32'h0000_0000, 4'hf, 1'b0);
         chk(66'(hit_q), 66'(0), "hit while disabled");
         nxt(rec(1'b0, (ra && b && s != MASTER_DMA) ? CMD_LINE_AHEAD : CMD_LINE, 4'h0, base,
             32'h0000_0000), RDM);
      end
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      cfg_r(BUF_CTRL_OFFSET, BUF_CTRL_RESET);
      final_report();
   end
   // The whole sequence needs about a thousand cycles; this bound only catches a hang.
   initial begin
      repeat (50000) @(posedge clk);
      failures++;
      final_report();
   end
endmodule // sdwb_buffer_tb_top
